// [src/dfpc_regs.sv]
/*
 * pull control register bank: lower/upper pull word, software output
 * enable and pull-range select, plus the sequencer that hands a whole
 * pull word to the pull engine after an upper-word write.
 * assumes: a serial slave front end delivers decoded 16-bit register
 * writes and reads as one-cycle strobes on CLK.
 */
`timescale 1ns/10ps
`default_nettype none
`include "dfpc_defs.svh"

// Summary of operation
// - upper register bits 15:11 read zero, ignore writes
// - bit 10 software driver enable, default off
// - hardware enable mode makes bit 10 writes inert
// - upper ten bits plus lower sixteen form word
// - pull word resets to zero, nominal frequency
// - pull word is signed two's complement
// - only upper-word writes start a new pull
// - range register bits 15:4 read zero
// - range codes 0-7: 6.25 to 125 ppm
// - range codes 8-15: 150 to 3200 ppm
// - range resets to factory default, then writable
// - pull starts within 140 us of write

module dfpc_regs #(
  parameter int unsigned APPLY_CYC = `DFPC_FDELAY_CYC,  // upper write to pull start
  parameter int unsigned DLY_W     = 16                  // width of the delay counter
) (
  // clock and reset
  input  wire logic                CLK,
  input  wire logic                RST,
  // register port from the serial slave
  input  wire logic [7:0]          REG_ADDR,
  input  wire logic [15:0]         REG_WDATA,
  input  wire logic                REG_WR,
  input  wire logic                REG_RD,
  output var  logic [15:0]         REG_RDATA,
  // device configuration
  input  wire logic [3:0]          FACTORY_RANGE,
  input  wire logic                OE_HW_MODE,
  input  wire logic                OE_PIN,
  // to the output driver and pull engine
  output logic                     DRIVER_EN,
  output var  dfpc_pkg::dfpc_word_t PULL_WORD,
  output var  logic                PULL_START,
  output logic                     PULL_BUSY,
  output logic [3:0]               RANGE_CODE,
  output logic [18:0]              RANGE_SPAN
);

  // ****************************************************************
  // storage
  // ****************************************************************
  logic [15:0]          lower_pull_bits_reg;  // offset 0x00
  logic [9:0]           upper_pull_bits_reg;  // offset 0x01 [9:0]
  logic                 sw_oe_reg;            // offset 0x01 [10]
  logic [3:0]           range_reg;            // offset 0x02 [3:0]
  dfpc_pkg::dfpc_word_t pend_word_reg;        // captured whole word
  dfpc_pkg::dfpc_state_e state_reg;           // apply sequencer
  logic [DLY_W-1:0]     cnt_reg;              // cycles spent waiting

  // decoded write strobes
  logic wr_lower;
  logic wr_upper;
  logic wr_range;
  logic apply_now;

  assign wr_lower  = REG_WR && (REG_ADDR == `DFPC_ADDR_LOWER);
  assign wr_upper  = REG_WR && (REG_ADDR == `DFPC_ADDR_UPPER);
  assign wr_range  = REG_WR && (REG_ADDR == `DFPC_ADDR_RANGE);
  // last waiting cycle; the write cycle itself counts as the first
  assign apply_now = (state_reg == dfpc_pkg::DFPC_WAIT) &&
                     (cnt_reg == DLY_W'(APPLY_CYC - 2));

  // ****************************************************************
  // lower pull bits: stored only, no frequency effect on their own
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (RST) begin
      lower_pull_bits_reg <= `DFPC_LOWER_RST;
    end else if (wr_lower) begin
      lower_pull_bits_reg <= REG_WDATA;
    end
  end

  // ****************************************************************
  // upper pull bits and software enable
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (RST) begin
      upper_pull_bits_reg <= `DFPC_UPPER_RST;
      sw_oe_reg           <= `DFPC_OE_RST;
    end else if (wr_upper) begin
      // bits 15:11 of the write are simply dropped
      upper_pull_bits_reg <= REG_WDATA[`DFPC_UPPER_MSB:0];
      if (!OE_HW_MODE) begin
        sw_oe_reg <= REG_WDATA[`DFPC_OE_BIT];
      end
      // under pin control the bit keeps its value
    end
  end

  // driver follows the pin or the bit, never both
  assign DRIVER_EN = OE_HW_MODE ? OE_PIN : sw_oe_reg;

  // ****************************************************************
  // pull range: factory default loaded while reset is held
  // ****************************************************************
  // reset is synchronous, so sampling the strap here is safe
  always_ff @(posedge CLK) begin
    if (RST) begin
      range_reg <= FACTORY_RANGE;
    end else if (wr_range) begin
      range_reg <= REG_WDATA[`DFPC_RANGE_MSB:0];
    end
  end

  assign RANGE_CODE = range_reg;

  // span lookup for the pull engine's scaling
  dfpc_range_lut u_lut (
    .clk      (CLK),
    .rst      (RST),
    .code     (range_reg),
    .span_reg (RANGE_SPAN)
  );

  // ****************************************************************
  // apply sequencer: capture whole word, start inside the window
  // ****************************************************************
  // a second upper write while waiting recaptures and restarts the
  // wait; the host keeps writes below the update rate anyway
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_reg     <= dfpc_pkg::DFPC_IDLE;
      cnt_reg       <= '0;
      pend_word_reg <= `DFPC_WORD_RST;
    end else if (wr_upper) begin
      state_reg     <= dfpc_pkg::DFPC_WAIT;
      cnt_reg       <= '0;
      // one snapshot, so the engine never sees half old, half new
      pend_word_reg <= {REG_WDATA[`DFPC_UPPER_MSB:0], lower_pull_bits_reg};
    end else begin
      case (state_reg)
        dfpc_pkg::DFPC_IDLE: begin
          cnt_reg <= '0;
        end
        dfpc_pkg::DFPC_WAIT: begin
          if (apply_now) begin
            state_reg <= dfpc_pkg::DFPC_IDLE;
            cnt_reg   <= '0;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        default: begin
          state_reg <= dfpc_pkg::DFPC_IDLE;
          cnt_reg   <= '0;
        end
      endcase
    end
  end

  assign PULL_BUSY = (state_reg == dfpc_pkg::DFPC_WAIT);

  // ****************************************************************
  // word handed to the pull engine
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (RST) begin
      PULL_WORD  <= `DFPC_WORD_RST;  // zero is the nominal frequency
      PULL_START <= 1'b0;
    end else begin
      PULL_START <= apply_now && !wr_upper;
      if (apply_now && !wr_upper) begin
        PULL_WORD <= pend_word_reg;  // signed offset
      end
    end
  end

  // ****************************************************************
  // read path: one cycle latency, unused bits and addresses read zero
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (RST) begin
      REG_RDATA <= 16'h0000;
    end else if (REG_RD) begin
      case (REG_ADDR)
        `DFPC_ADDR_LOWER: REG_RDATA <= lower_pull_bits_reg;
        `DFPC_ADDR_UPPER: REG_RDATA <= {5'h00, sw_oe_reg, upper_pull_bits_reg};
        `DFPC_ADDR_RANGE: REG_RDATA <= {12'h000, range_reg};
        default:          REG_RDATA <= 16'h0000;
      endcase
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_upper_rsvd_zero: assert property (REG_RD && REG_ADDR == `DFPC_ADDR_UPPER |=> REG_RDATA[15:11] == 5'h00)
    else $error("upper register reserved bits not zero");
  a_range_rsvd_zero: assert property (REG_RD && REG_ADDR == `DFPC_ADDR_RANGE |=> REG_RDATA[15:4] == 12'h000)
    else $error("range register reserved bits not zero");
  a_oe_sw_follow: assert property (wr_upper && !OE_HW_MODE ##1 !OE_HW_MODE |-> DRIVER_EN == $past(REG_WDATA[10]))
    else $error("driver enable does not follow software bit");
  a_oe_hw_inert: assert property (wr_upper && OE_HW_MODE |=> $stable(sw_oe_reg) && (!OE_HW_MODE || DRIVER_EN == OE_PIN))
    else $error("software enable write acted under pin control");
  a_word_capture: assert property (wr_upper |=> pend_word_reg == {$past(REG_WDATA[9:0]), $past(lower_pull_bits_reg)})
    else $error("captured pull word is mixed");
  a_lower_no_pull: assert property (wr_lower && !PULL_BUSY |=> !PULL_BUSY ##1 $stable(PULL_WORD))
    else $error("lower word write changed the pull");
  a_apply_bound: assert property (PULL_BUSY |-> cnt_reg < DLY_W'(APPLY_CYC))
    else $error("pull start later than allowed");
  a_apply_word: assert property (PULL_START |-> PULL_WORD == $past(pend_word_reg) && !PULL_BUSY)
    else $error("applied word differs from captured word");
  a_word_moves: assert property ($changed(PULL_WORD) |-> PULL_START)
    else $error("pull word changed without a start");
  a_range_write: assert property (wr_range |=> RANGE_CODE == $past(REG_WDATA[3:0]) ##1 $stable(RANGE_CODE) || $past(REG_WR))
    else $error("range write not taken");

  c_full_update: cover property (wr_lower ##[1:4] wr_upper ##[1:1000] PULL_START);
  c_hw_oe_write: cover property (wr_upper && OE_HW_MODE);
  c_restart:     cover property (PULL_BUSY && wr_upper);
  c_range_read:  cover property (wr_range ##1 REG_RD && REG_ADDR == `DFPC_ADDR_RANGE);

endmodule : dfpc_regs

`default_nettype wire

// [src/dfpc_defs.svh]
/*
 * register offsets, field positions, reset values and timing counts
 * for the pull control register bank.
 * assumes: included by bare name from the bank's design files.
 */
`ifndef DFPC_DEFS_SVH
`define DFPC_DEFS_SVH

// ****************************************************************
// register offsets (byte-wide register address of the serial port)
// ****************************************************************
`define DFPC_ADDR_LOWER      8'h00
`define DFPC_ADDR_UPPER      8'h01
`define DFPC_ADDR_RANGE      8'h02

// ****************************************************************
// field positions
// ****************************************************************
`define DFPC_UPPER_MSB       9
`define DFPC_OE_BIT          10
`define DFPC_RANGE_MSB       3
`define DFPC_WORD_W          26
`define DFPC_DATA_W          16

// ****************************************************************
// reset values
// ****************************************************************
`define DFPC_LOWER_RST       16'h0000
`define DFPC_UPPER_RST       10'h000
`define DFPC_OE_RST          1'b0
`define DFPC_WORD_RST        26'h0000000

// ****************************************************************
// timing: latest start of the pull after the upper word lands
// ****************************************************************
`define DFPC_CLK_PERIOD_PS   8000
`define DFPC_FDELAY_US       140
// longest time, so rounded down to whole cycles
`define DFPC_FDELAY_CYC      ((`DFPC_FDELAY_US * 1000000) / `DFPC_CLK_PERIOD_PS)

`endif

// [src/dfpc_pkg.sv]
/*
 * types shared by the pull control register bank.
 * assumes: referenced with explicit package scope, never imported.
 */
`default_nettype none
package dfpc_pkg;

  // signed pull word as seen by the pull engine
  typedef logic signed [25:0] dfpc_word_t;

  // apply sequencer states
  typedef enum logic [0:0] {
    DFPC_IDLE = 1'b0,  // nothing pending
    DFPC_WAIT = 1'b1   // captured word waiting for its start slot
  } dfpc_state_e;

endpackage : dfpc_pkg

`default_nettype wire

// [src/dfpc_range_lut.sv]
/*
 * decodes the 4-bit pull-range code into the half-range span in
 * hundredths of a ppm, registered.
 * assumes: one clock, synchronous active-high reset.
 */
`timescale 1ns/10ps
`default_nettype none

module dfpc_range_lut (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // range code in, span out
  input  wire logic [3:0]  code,
  output var  logic [18:0] span_reg
);

  // ****************************************************************
  // table lookup, one cycle of latency
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      span_reg <= 19'h00000;
    end else begin
      case (code)
        4'h0:    span_reg <= 19'h00271;  // 6.25
        4'h1:    span_reg <= 19'h003E8;  // 10
        4'h2:    span_reg <= 19'h004E2;  // 12.5
        4'h3:    span_reg <= 19'h009C4;  // 25
        4'h4:    span_reg <= 19'h01388;  // 50
        4'h5:    span_reg <= 19'h01F40;  // 80
        4'h6:    span_reg <= 19'h02710;  // 100
        4'h7:    span_reg <= 19'h030D4;  // 125
        4'h8:    span_reg <= 19'h03A98;  // 150
        4'h9:    span_reg <= 19'h04E20;  // 200
        4'hA:    span_reg <= 19'h09C40;  // 400
        4'hB:    span_reg <= 19'h0EA60;  // 600
        4'hC:    span_reg <= 19'h13880;  // 800
        4'hD:    span_reg <= 19'h1D4C0;  // 1200
        4'hE:    span_reg <= 19'h27100;  // 1600
        default: span_reg <= 19'h4E200;  // 3200
      endcase
    end
  end

endmodule : dfpc_range_lut

`default_nettype wire

// [verification/dfpc_host_model.sv]
/* host model: the serial master's parallel side, issuing register strobes.
   assumes: the bench calls its tasks by hierarchical name. */
`timescale 1ns/10ps
`default_nettype none
module dfpc_host_model #(
  parameter int GAP_CYC = 40  // shortened update spacing
) (
  // clock
  input  wire logic        CLK,
  // register strobes
  output var  logic [7:0]  REG_ADDR,
  output var  logic [15:0] REG_WDATA,
  output var  logic        REG_WR,
  output var  logic        REG_RD,
  input  wire logic [15:0] REG_RDATA
);
  int since_upd = GAP_CYC;  // cycles since last upper write
  initial begin
    REG_ADDR  = 8'h00;
    REG_WDATA = 16'h0000;
    REG_WR    = 1'h0;
    REG_RD    = 1'h0;
  end
  // spacing counter for pull updates
  always @(posedge CLK) begin
    since_upd <= (REG_WR && REG_ADDR == 8'h01) ? 0 : since_upd + 1;
  end
  // one write; released lines are scrambled, never left valid
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge CLK);
    REG_ADDR  = a;
    REG_WDATA = d;
    REG_WR    = 1'h1;
    @(negedge CLK);
    REG_WR    = 1'h0;
    REG_ADDR  = ~a;
    REG_WDATA = ~d;
  endtask : wr
  // one read; data taken the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge CLK);
    REG_ADDR = a;
    REG_RD   = 1'h1;
    @(negedge CLK);
    REG_RD   = 1'h0;
    REG_ADDR = ~a;
    d        = REG_RDATA;
  endtask : rd
  // whole pull word update, lower half first
  task automatic pull(input logic [25:0] w, input logic oe);
    while (since_upd < GAP_CYC) @(negedge CLK);
    wr(8'h00, w[15:0]);
    wr(8'h01, {5'h00, oe, w[25:16]});
  endtask : pull
endmodule : dfpc_host_model
`default_nettype wire

// [verification/tb_top.sv]
/* bench for the pull control register bank.
   assumes: host model drives the strobes at the falling edge. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int APPLY = 20;  // shortened apply delay
  localparam int SPAN[16] = '{625, 1000, 1250, 2500, 5000, 8000, 10000, 12500,
    15000, 20000, 40000, 60000, 80000, 120000, 160000, 320000};
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [3:0] fact = 4'hA;  // factory range code
  logic hwm = 1'h0;         // pin controls enable
  logic pin = 1'h0;
  wire logic [7:0] addr;
  wire logic [15:0] wdata, rdata;
  wire logic wr, rd, drv_en, start, busy;
  wire logic [3:0] rcode;
  wire logic [18:0] rspan;
  wire dfpc_pkg::dfpc_word_t word;
  int error_cnt = 0;
  int samples_checked = 0;
  always #4 clk = ~clk;
  dfpc_host_model #(.GAP_CYC(40)) h_u (.CLK(clk), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata));
  dfpc_regs #(.APPLY_CYC(APPLY)) dut_u (.CLK(clk), .RST(rst), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .FACTORY_RANGE(fact),
    .OE_HW_MODE(hwm), .OE_PIN(pin), .DRIVER_EN(drv_en), .PULL_WORD(word),
    .PULL_START(start), .PULL_BUSY(busy), .RANGE_CODE(rcode), .RANGE_SPAN(rspan));
  // single compare point
  task automatic chk(input logic [25:0] s, input logic [25:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %0t: got %h expected %h", $time, s, e);
    end
  endtask : chk
  // waits for the start pulse; the write cycle counts as the first of APPLY,
  // so the pulse shows APPLY-1 edges after the upper write edge
  task automatic wait_start(input int skip, input logic [25:0] e);
    int n;
    n = skip;
    chk(26'(busy), 26'h1);
    while (start !== 1'h1 && n < APPLY + 3) begin
      @(negedge clk);
      n++;
    end
    chk(26'(n), 26'(APPLY - 1));
    chk(word, e);
    chk(26'(busy), 26'h0);
  endtask : wait_start
  // values straight out of reset
  task automatic t_reset;
    logic [15:0] d;
    h_u.rd(8'h00, d);
    chk(26'(d), 26'h0);
    h_u.rd(8'h01, d);
    chk(26'(d), 26'h0);
    h_u.rd(8'h02, d);
    chk(26'(d), 26'hA);
    chk(word, 26'h0);
    chk(26'(drv_en), 26'h0);
    chk(26'(rspan), 26'd40000);
  endtask : t_reset
  // negative word, junk in the read-only bits
  task automatic t_pull;
    logic [15:0] d;
    h_u.wr(8'h00, 16'h1234);
    h_u.wr(8'h01, 16'hFFFF);
    chk(26'(drv_en), 26'h1);
    wait_start(0, 26'h3FF1234);
    h_u.rd(8'h01, d);
    chk(26'(d), 26'h07FF);
  endtask : t_pull
  // lower write while pending, then a lower write alone
  task automatic t_mixed;
    int n;
    n = 0;
    h_u.pull(26'h0005678, 1'h0);
    h_u.wr(8'h00, 16'hBEEF);
    wait_start(2, 26'h0005678);
    chk(26'(drv_en), 26'h0);
    h_u.wr(8'h00, 16'h4321);
    repeat (APPLY + 5) begin
      @(negedge clk);
      if (start === 1'h1) n++;
    end
    chk(26'(n), 26'h0);
    chk(word, 26'h0005678);
  endtask : t_mixed
  // pin control makes the software bit inert
  task automatic t_hw;
    hwm = 1'h1;
    h_u.pull(26'h005BEEF, 1'h1);
    chk(26'(drv_en), 26'h0);
    pin = 1'h1;
    @(negedge clk);
    chk(26'(drv_en), 26'h1);
    hwm = 1'h0;
    @(negedge clk);
    chk(26'(drv_en), 26'h0);
    wait_start(2, 26'h005BEEF);
  endtask : t_hw
  // every range code, then an unmapped address
  task automatic t_range;
    logic [15:0] d;
    for (int c = 0; c < 16; c++) begin
      h_u.wr(8'h02, 16'hFFF0 | 16'(c));
      h_u.rd(8'h02, d);
      chk(26'(d), 26'(c));
      chk(26'(rcode), 26'(c));
      chk(26'(rspan), 26'(SPAN[c]));
    end
    h_u.wr(8'h05, 16'hFFFF);
    h_u.rd(8'h05, d);
    chk(26'(d), 26'h0);
  endtask : t_range
  // reset while a pull waits: word, enable and range come back clean
  task automatic t_rerun;
    logic [15:0] d;
    int n;
    n = 0;
    h_u.pull(26'h2000001, 1'h1);
    chk(26'(drv_en), 26'h1);
    fact = 4'h3;
    rst  = 1'h1;
    repeat (2) @(negedge clk);
    rst  = 1'h0;
    chk(26'(busy), 26'h0);
    chk(word, 26'h0);
    chk(26'(drv_en), 26'h0);
    h_u.rd(8'h02, d);
    chk(26'(d), 26'h3);
    chk(26'(rspan), 26'(SPAN[3]));
    h_u.rd(8'h01, d);
    chk(26'(d), 26'h0);
    repeat (APPLY + 3) begin
      @(negedge clk);
      if (start === 1'h1) n++;
    end
    chk(26'(n), 26'h0);
  endtask : t_rerun
  // verdict and end of run
  task automatic report_and_stop;
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop
  // main sequence
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'h0;
    t_reset();
    t_pull();
    t_mixed();
    t_hw();
    t_range();
    t_rerun();
    report_and_stop();
  end
  // watchdog, far beyond the expected run
  initial begin
    #100000;
    error_cnt++;
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
